/* File: verif/general_timer_control_assertions.sv */
// Port checker for the timer pair
`timescale 1ns/1ps
module general_timer_control_assertions (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic idle_mode,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic run_even,
	input wire logic run_odd
);
	// Even control copy: enable, halt in idle, pair
	logic [2:0] ev_q;
	wire wr_even = psel && penable && pready && pwrite && paddr == 8'h00;
	wire rd_ctrl = pready && !pwrite && (paddr == 8'h00 || paddr == 8'h08);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ev_q <= 3'h0;
		end else if (wr_even) begin
			ev_q <= {pwdata[15], pwdata[13], pwdata[3]};
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence access_s; psel && penable && !pready; endsequence
	sequence answer_s; pready ##1 !pready; endsequence
	a_ready_wait: assert property (access_s |=> answer_s) else $error("pready timing wrong");
	a_err_decode: assert property (pready |-> pslverr == (paddr[1:0] != 2'h0 || paddr > 8'h0c))
		else $error("pslverr decode wrong");
	a_ctrl_zero_bits: assert property (rd_ctrl |-> (prdata & 32'hffff5f05) == 32'h0)
		else $error("unused control bit reads one");
	a_odd_no_pair: assert property (pready && !pwrite && paddr == 8'h08 |-> !prdata[3])
		else $error("odd pair bit reads one");
	a_gate_ignored: assert property (rd_ctrl && prdata[1] |-> !prdata[7])
		else $error("gate bit reads one with external clock");
	a_disable_stops: assert property (wr_even && !pwdata[15] |-> ##[1:3] !run_even)
		else $error("timer still runs after disable");
	a_idle_halts: assert property ((idle_mode && ev_q[1])[*5] |-> !run_even)
		else $error("timer runs in idle with halt set");
	a_idle_runs: assert property ((idle_mode && ev_q == 3'h4)[*5] |-> run_even)
		else $error("timer stopped in idle without halt");
	a_pair_follows: assert property ((ev_q[0] && !idle_mode)[*5] |-> run_odd == run_even)
		else $error("paired odd timer not following even");
endmodule // general_timer_control_assertions

bind general_timer_control general_timer_control_assertions u_chk (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .idle_mode(idle_mode), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .run_even(run_even), .run_odd(run_odd));

/* File: verif/tb_top.sv */
// Self-checking bench for the timer pair
`timescale 1ns/1ps
`include "general_timer_control_params.svh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin bad_count++; \
	$display("[ERR] %0t got %h exp %h", $time, a, b); end end
module tb_top;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, idle_mode = 0;
	logic ext_clk_even = 0, ext_clk_odd = 0, gate_even = 0, gate_odd = 0;
	logic [7:0] paddr = 8'h0;
	logic [31:0] pwdata = 32'h0, prdata, rd, d0;
	logic pready, pslverr, run_even, run_odd;
	int bad_count = 0, total_checks = 0;
	int ratio [8] = '{1, 2, 4, 8, 16, 32, 64, 256};
	general_timer_control u_general_timer_control (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.idle_mode(idle_mode), .ext_clk_even(ext_clk_even), .ext_clk_odd(ext_clk_odd),
		.gate_even(gate_even), .gate_odd(gate_odd), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .run_even(run_even), .run_odd(run_odd));
	initial forever #50 pclk = ~pclk;
	task automatic finish_test();
		$display("checks %0d errors %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic e);
		// One idle cycle always separates two transfers
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		`CHK(pslverr, e)
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Count advance between two reads w + 4 cycles apart
	task automatic span(input int w, output logic [15:0] n);
		xfer(1'b0, `GTC_OFS_COUNT_EVEN, 32'h0, 1'b0);
		d0 = rd;
		repeat (w) @(posedge pclk);
		xfer(1'b0, `GTC_OFS_COUNT_EVEN, 32'h0, 1'b0);
		n = rd[15:0] - d0[15:0];
	endtask
	function automatic logic [31:0] exp_ctrl(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] v;
		v = d & (a == `GTC_OFS_CTRL_EVEN ? 32'h0000a0fa : 32'h0000a0f2);
		if (v[1]) v[7] = 1'b0;
		return v;
	endfunction
	initial begin
		logic [15:0] n;
		logic [7:0] a;
		void'($urandom(32'haf6ab8a5));
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		xfer(1'b0, `GTC_OFS_CTRL_EVEN, 32'h0, 1'b0);
		`CHK(rd, 32'h0)
		for (int i = 0; i < 16; i++) begin
			a = i[0] ? `GTC_OFS_CTRL_ODD : `GTC_OFS_CTRL_EVEN;
			d0 = $urandom & 32'hffff7fff;
			d0[6:4] = i[3:1];
			xfer(1'b1, a, d0, 1'b0);
			xfer(1'b0, a, 32'h0, 1'b0);
			`CHK(rd, exp_ctrl(a, d0))
		end
		xfer(1'b1, 8'h10, 32'hffffffff, 1'b1);
		xfer(1'b0, 8'h10, 32'h0, 1'b1);
		`CHK(rd, 32'h0)
		for (int k = 0; k < 8; k++) begin
			xfer(1'b1, `GTC_OFS_CTRL_EVEN, 32'h00008000 | (k << 4), 1'b0);
			span(4 * ratio[k] - 4, n);
			`CHK(n, 16'h4)
		end
		xfer(1'b1, `GTC_OFS_CTRL_EVEN, 32'h0, 1'b0);
		span(4, n);
		`CHK(n, 16'h0)
		`CHK(run_even, 1'b0)
		xfer(1'b1, `GTC_OFS_CTRL_EVEN, 32'h00008082, 1'b0);
		xfer(1'b0, `GTC_OFS_COUNT_EVEN, 32'h0, 1'b0);
		d0 = rd;
		repeat (10) begin
			repeat (4) @(posedge pclk);
			ext_clk_even <= ~ext_clk_even;
			ext_clk_odd <= ~ext_clk_odd;
		end
		repeat (4) @(posedge pclk);
		xfer(1'b0, `GTC_OFS_COUNT_EVEN, 32'h0, 1'b0);
		`CHK(rd[15:0] - d0[15:0], 16'h5)
		xfer(1'b1, `GTC_OFS_CTRL_EVEN, 32'h00008080, 1'b0);
		span(8, n);
		`CHK(n, 16'h0)
		gate_even <= 1'b1;
		gate_odd <= 1'b1;
		repeat (4) @(posedge pclk);
		span(8, n);
		`CHK(n, 16'hc)
		xfer(1'b1, `GTC_OFS_CTRL_EVEN, 32'h0000a000, 1'b0);
		idle_mode <= 1'b1;
		repeat (5) @(posedge pclk);
		span(4, n);
		`CHK(n, 16'h0)
		xfer(1'b1, `GTC_OFS_CTRL_EVEN, 32'h00008000, 1'b0);
		span(4, n);
		`CHK(n, 16'h8)
		idle_mode <= 1'b0;
		xfer(1'b1, `GTC_OFS_CTRL_EVEN, 32'h0, 1'b0);
		xfer(1'b1, `GTC_OFS_COUNT_EVEN, 32'h0000fff0, 1'b0);
		xfer(1'b1, `GTC_OFS_CTRL_EVEN, 32'h00008008, 1'b0);
		repeat (40) @(posedge pclk);
		`CHK(run_odd, 1'b1)
		xfer(1'b0, `GTC_OFS_COUNT_ODD, 32'h0, 1'b0);
		`CHK(rd[15:0], 16'h1)
		// Odd halt bit stops the pair in idle until software clears it
		xfer(1'b1, `GTC_OFS_CTRL_ODD, 32'h00002000, 1'b0);
		idle_mode <= 1'b1;
		repeat (5) @(posedge pclk);
		span(4, n);
		`CHK(n, 16'h0)
		xfer(1'b1, `GTC_OFS_CTRL_ODD, 32'h0, 1'b0);
		span(4, n);
		`CHK(n, 16'h8)
		idle_mode <= 1'b0;
		// Odd timer on its own: gated, 1:2, internal clock
		xfer(1'b1, `GTC_OFS_CTRL_EVEN, 32'h0, 1'b0);
		xfer(1'b1, `GTC_OFS_CTRL_ODD, 32'h00008090, 1'b0);
		xfer(1'b0, `GTC_OFS_COUNT_ODD, 32'h0, 1'b0);
		d0 = rd;
		repeat (12) @(posedge pclk);
		xfer(1'b0, `GTC_OFS_COUNT_ODD, 32'h0, 1'b0);
		`CHK(rd[15:0] - d0[15:0], 16'h8)
		`CHK(run_odd, 1'b1)
		`CHK(run_even, 1'b0)
		gate_odd <= 1'b0;
		repeat (4) @(posedge pclk);
		xfer(1'b0, `GTC_OFS_COUNT_ODD, 32'h0, 1'b0);
		d0 = rd;
		repeat (12) @(posedge pclk);
		xfer(1'b0, `GTC_OFS_COUNT_ODD, 32'h0, 1'b0);
		`CHK(rd[15:0] - d0[15:0], 16'h0)
		// Odd timer on its external clock, gate bit ignored
		xfer(1'b1, `GTC_OFS_CTRL_ODD, 32'h00008082, 1'b0);
		xfer(1'b0, `GTC_OFS_COUNT_ODD, 32'h0, 1'b0);
		d0 = rd;
		repeat (6) begin
			repeat (4) @(posedge pclk);
			ext_clk_odd <= ~ext_clk_odd;
		end
		repeat (4) @(posedge pclk);
		xfer(1'b0, `GTC_OFS_COUNT_ODD, 32'h0, 1'b0);
		`CHK(rd[15:0] - d0[15:0], 16'h3)
		finish_test();
	end
	initial begin
		#2000000;
		bad_count++;
		finish_test();
	end
endmodule // tb_top

/* File: verilog/general_timer_control.sv */
// Even/odd 16-bit timer pair with control registers on APB
// What this block does
// R1 - Enable bit 15 runs the timer, and clearing it stops the timer.
// R2 - With halt-in-idle bit 13 set the timer stops while the chip idles, else keeps counting.
// R3 - With the external clock selected the gate bit 7 is ignored and reads as zero.
// R4 - With the internal clock selected the gate bit turns gated accumulation on or off.
// R5 - Bits 6 to 4 divide the input clock by 1, 2, 4, 8, 16, 32, 64 or 256.
// R6 - Only the even timer has the 32-bit pairing bit; the odd one has none.
// R7 - In 32-bit mode enable, gate, prescale and clock source come from the even timer only.
// R8 - Software clears the odd timer's halt-in-idle bit to keep a pair running in idle.
// R9 - Unimplemented control bits read as zero.
// R10 - Software avoids register access in the cycle right after clearing enable at 1:1.
// R11 - Clock source zero counts the bus clock, one counts the external clock input.
// R12 - Gated mode advances on prescaled internal ticks only while the gate is high.
`timescale 1ns/1ps
`include "general_timer_control_params.svh"
module general_timer_control (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic idle_mode,
	input wire logic ext_clk_even,
	input wire logic ext_clk_odd,
	input wire logic gate_even,
	input wire logic gate_odd,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic run_even,
	output logic run_odd
);
	general_timer_control_pkg::timer_ctrl_t ctrl_even_q;
	general_timer_control_pkg::timer_ctrl_t ctrl_odd_q;
	general_timer_control_pkg::timer_ctrl_t eff_odd;
	general_timer_control_pkg::count_t count_even_q;
	general_timer_control_pkg::count_t count_odd_q;
	logic [4:0] meta_q;
	logic [4:0] sync_q;
	logic [1:0] last_clk_q;
	logic idle_s;
	logic gate_even_s;
	logic gate_odd_s;
	logic edge_even;
	logic edge_odd;
	logic paired;
	logic halt_even;
	logic halt_odd;
	logic active_even;
	logic active_odd;
	logic ps_run_even;
	logic ps_run_odd;
	logic ps_in_even;
	logic ps_in_odd;
	logic tick_even;
	logic tick_odd;
	logic carry_even;
	logic access;
	logic commit;
	logic wr_ctrl_even;
	logic wr_ctrl_odd;
	logic wr_count_even;
	logic wr_count_odd;
	logic mapped;
	logic [31:0] rdata_d;

	// Control word as software sees it
	function automatic logic [31:0] ctrl_read(input general_timer_control_pkg::timer_ctrl_t c);
		logic [31:0] w;
		w = 32'h0000_0000; // R9
		w[`GTC_BIT_ENABLE] = c.enable;
		w[`GTC_BIT_HALT_IN_IDLE] = c.halt_in_idle;
		w[`GTC_BIT_GATED] = c.gated_accum_enable & ~c.clock_source_select; // R3
		w[`GTC_BIT_PRESCALE_HI:`GTC_BIT_PRESCALE_LO] = c.input_prescale_select;
		w[`GTC_BIT_PAIR_WIDE] = c.pair_wide_select;
		w[`GTC_BIT_CLOCK_SOURCE] = c.clock_source_select;
		ctrl_read = w;
	endfunction

	// Control word taken from a bus write
	function automatic general_timer_control_pkg::timer_ctrl_t ctrl_write(input logic [31:0] w);
		general_timer_control_pkg::timer_ctrl_t c;
		c.enable = w[`GTC_BIT_ENABLE];
		c.halt_in_idle = w[`GTC_BIT_HALT_IN_IDLE];
		c.gated_accum_enable = w[`GTC_BIT_GATED];
		c.input_prescale_select = w[`GTC_BIT_PRESCALE_HI:`GTC_BIT_PRESCALE_LO];
		c.pair_wide_select = w[`GTC_BIT_PAIR_WIDE];
		c.clock_source_select = w[`GTC_BIT_CLOCK_SOURCE];
		ctrl_write = c;
	endfunction

	// Pin synchronisers: idle, two gates, two external clocks
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_q <= 5'h00;
			sync_q <= 5'h00;
		end else begin
			meta_q <= {ext_clk_odd, ext_clk_even, gate_odd, gate_even, idle_mode};
			sync_q <= meta_q;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_clk_q <= 2'h0;
		end else begin
			last_clk_q <= sync_q[4:3];
		end
	end

	assign idle_s = sync_q[0];
	assign gate_even_s = sync_q[1];
	assign gate_odd_s = sync_q[2];
	assign edge_even = sync_q[3] & ~last_clk_q[0];
	assign edge_odd = sync_q[4] & ~last_clk_q[1];

	// Odd timer follows the even settings when paired
	assign paired = ctrl_even_q.pair_wide_select;
	always_comb begin
		eff_odd = ctrl_odd_q;
		if (paired) begin
			eff_odd = ctrl_even_q; // R7
		end
	end

	// In a pair either halt bit stops both halves in idle
	assign halt_even = idle_s & (ctrl_even_q.halt_in_idle | (paired & ctrl_odd_q.halt_in_idle)); // R2 R8
	assign halt_odd = paired ? halt_even : (idle_s & ctrl_odd_q.halt_in_idle); // R2
	assign active_even = ctrl_even_q.enable & ~halt_even; // R1
	assign active_odd = eff_odd.enable & ~halt_odd; // R1

	// Source pick and gating ahead of the prescaler
	assign ps_in_even = ctrl_even_q.clock_source_select ? edge_even : 1'b1; // R11
	assign ps_in_odd = eff_odd.clock_source_select ? edge_odd : 1'b1; // R11
	assign ps_run_even = active_even & (ctrl_even_q.clock_source_select
		| ~ctrl_even_q.gated_accum_enable | gate_even_s); // R4 R12
	assign ps_run_odd = active_odd & ~paired & (eff_odd.clock_source_select
		| ~eff_odd.gated_accum_enable | gate_odd_s); // R4 R12

	input_prescaler u_prescale_even (
		.pclk(pclk),
		.presetn(presetn),
		.run(ps_run_even),
		.tick_in(ps_in_even),
		.sel(ctrl_even_q.input_prescale_select),
		.tick_out(tick_even)
	);

	input_prescaler u_prescale_odd (
		.pclk(pclk),
		.presetn(presetn),
		.run(ps_run_odd),
		.tick_in(ps_in_odd),
		.sel(eff_odd.input_prescale_select),
		.tick_out(tick_odd)
	);

	// APB decode; writes land on the edge that completes the transfer
	assign access = psel & penable & ~pready;
	assign commit = psel & penable & pready & pwrite;
	assign wr_ctrl_even = commit & (paddr == `GTC_OFS_CTRL_EVEN);
	assign wr_ctrl_odd = commit & (paddr == `GTC_OFS_CTRL_ODD);
	assign wr_count_even = commit & (paddr == `GTC_OFS_COUNT_EVEN);
	assign wr_count_odd = commit & (paddr == `GTC_OFS_COUNT_ODD);

	always_comb begin
		mapped = 1'b1;
		case (paddr)
			`GTC_OFS_CTRL_EVEN: rdata_d = ctrl_read(ctrl_even_q);
			`GTC_OFS_COUNT_EVEN: rdata_d = {16'h0000, count_even_q}; // R9
			`GTC_OFS_CTRL_ODD: rdata_d = ctrl_read(ctrl_odd_q);
			`GTC_OFS_COUNT_ODD: rdata_d = {16'h0000, count_odd_q};
			default: begin
				rdata_d = 32'h0000_0000;
				mapped = 1'b0;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= access;
			pslverr <= access & ~mapped;
			if (access && !pwrite) begin
				prdata <= rdata_d;
			end
		end
	end

	// Control registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_even_q <= `GTC_CTRL_RESET;
		end else if (wr_ctrl_even) begin
			ctrl_even_q <= ctrl_write(pwdata);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_odd_q <= `GTC_CTRL_RESET;
		end else if (wr_ctrl_odd) begin
			ctrl_odd_q <= ctrl_write(pwdata);
			ctrl_odd_q.pair_wide_select <= 1'b0; // R6
		end
	end

	// Counters; the odd half takes the even carry when paired
	assign carry_even = tick_even & (count_even_q == `GTC_COUNT_MAX);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_even_q <= `GTC_COUNT_RESET;
		end else if (wr_count_even) begin
			count_even_q <= pwdata[15:0];
		end else if (tick_even) begin
			count_even_q <= count_even_q + 16'h0001;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_odd_q <= `GTC_COUNT_RESET;
		end else if (wr_count_odd) begin
			count_odd_q <= pwdata[15:0];
		end else if (paired ? carry_even : tick_odd) begin // R7
			count_odd_q <= count_odd_q + 16'h0001;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_even <= 1'b0;
			run_odd <= 1'b0;
		end else begin
			run_even <= active_even;
			run_odd <= active_odd;
		end
	end
endmodule // general_timer_control

/* File: verilog/general_timer_control_params.svh */
// Register offsets, field positions and reset values of the timer pair
`ifndef GENERAL_TIMER_CONTROL_PARAMS_SVH
`define GENERAL_TIMER_CONTROL_PARAMS_SVH

`define GTC_OFS_CTRL_EVEN 8'h00
`define GTC_OFS_COUNT_EVEN 8'h04
`define GTC_OFS_CTRL_ODD 8'h08
`define GTC_OFS_COUNT_ODD 8'h0c

`define GTC_BIT_ENABLE 15
`define GTC_BIT_HALT_IN_IDLE 13
`define GTC_BIT_GATED 7
`define GTC_BIT_PRESCALE_HI 6
`define GTC_BIT_PRESCALE_LO 4
`define GTC_BIT_PAIR_WIDE 3
`define GTC_BIT_CLOCK_SOURCE 1

`define GTC_CTRL_RESET 8'h00
`define GTC_COUNT_RESET 16'h0000
`define GTC_COUNT_MAX 16'hffff

`endif

/* File: verilog/general_timer_control_pkg.sv */
// Types shared by the timer pair and its prescaler
package general_timer_control_pkg;
	typedef logic [15:0] count_t;
	typedef logic [2:0] prescale_t;
	typedef struct packed {
		logic enable;
		logic halt_in_idle;
		logic gated_accum_enable;
		prescale_t input_prescale_select;
		logic pair_wide_select;
		logic clock_source_select;
	} timer_ctrl_t;
endpackage

/* File: verilog/input_prescaler.sv */
// Input clock prescaler with eight division ratios
`timescale 1ns/1ps
module input_prescaler (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic run,
	input wire logic tick_in,
	input wire general_timer_control_pkg::prescale_t sel,
	output logic tick_out
);
	logic [7:0] count_q;
	logic at_last;

	// Terminal count for ratios 1,2,4,8,16,32,64,256
	function automatic logic [7:0] last_count(input general_timer_control_pkg::prescale_t s);
		case (s)
			3'h0: last_count = 8'h00;
			3'h1: last_count = 8'h01;
			3'h2: last_count = 8'h03;
			3'h3: last_count = 8'h07;
			3'h4: last_count = 8'h0f;
			3'h5: last_count = 8'h1f;
			3'h6: last_count = 8'h3f;
			default: last_count = 8'hff;
		endcase
	endfunction

	assign at_last = (count_q >= last_count(sel)); // R5
	assign tick_out = run & tick_in & at_last;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_q <= 8'h00;
		end else if (!run) begin
			count_q <= 8'h00;
		end else if (tick_in) begin
			if (at_last) begin
				count_q <= 8'h00;
			end else begin
				count_q <= count_q + 8'h01;
			end
		end
	end
endmodule // input_prescaler
